// *** rtl/awd_top.sv ***
// Watchdog timer core with its register file and interrupt logic.
`timescale 1ns/1ps
`include "awd_map.svh"
module awd_top #(
	parameter int SEC_CYCLES = `AWD_SECOND_NS / `AWD_CLK_PERIOD_NS
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic game_port_access,
	input wire logic kbd_irq,
	input wire logic mouse_irq,
	input wire logic kbc_force_line,
	output logic [15:0] irq_lines,
	output logic wdt_timeout,
	output logic irq
);

	// ***************************************************************
	// Declarations
	// ***************************************************************
	logic unit_sec;
	logic [7:0] count_val;
	logic [6:0] src_cfg;
	logic kbc_en;
	logic force_sw;
	logic kbc_pulse;
	logic [`AWD_INT_W-1:0] int_stat;
	logic [`AWD_INT_W-1:0] int_mask;
	logic [7:0] remaining;
	awd_pkg::awd_state_t state;
	logic wr_unit;
	logic wr_count;
	logic wr_src;
	logic wr_ctrl;
	logic wr_mask;
	logic rd_stat;
	logic restart_evt;
	logic reload;
	logic force_any;
	logic timeout_evt;
	logic armed;
	logic [3:0] irq_map;
	logic [7:0] next_rdata;

	awd_tick_if tif();

	// ***************************************************************
	// Register decode
	// ***************************************************************

	// One strobe per register; the master never drives both strobes at once.
	assign wr_unit = reg_wr && (reg_addr == `AWD_ADDR_UNIT);
	assign wr_count = reg_wr && (reg_addr == `AWD_ADDR_COUNT);
	assign wr_src = reg_wr && (reg_addr == `AWD_ADDR_SOURCES);
	assign wr_ctrl = reg_wr && (reg_addr == `AWD_ADDR_CTRL);
	assign wr_mask = reg_wr && (reg_addr == `AWD_ADDR_INT_MASK);
	assign rd_stat = reg_rd && (reg_addr == `AWD_ADDR_INT_STAT);
	assign irq_map = src_cfg[6:3];

	// ***************************************************************
	// Configuration registers
	// ***************************************************************

	// Only the unit bit is stored; reserved bits cannot hold anything but zero.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			unit_sec <= 1'b0;
		end else if (wr_unit) begin
			unit_sec <= reg_wdata[`AWD_BIT_UNIT_SEC];
		end
	end

	// Time-out value, compared against zero to enable the watchdog.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			count_val <= `AWD_RST_BYTE;
		end else if (wr_count) begin
			count_val <= reg_wdata;
		end
	end

	// Restart sources and IRQ mapping; the reserved bit 3 is not kept.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			src_cfg <= 7'h00;
		end else if (wr_src) begin
			src_cfg <= {reg_wdata[`AWD_MAP_HI:`AWD_MAP_LO], reg_wdata[`AWD_BIT_SRC_MOUSE:0]};
		end
	end

	// Force line enable; reserved control bits 7 to 4 and 1 are dropped on write.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			kbc_en <= 1'b0;
		end else if (wr_ctrl) begin
			kbc_en <= reg_wdata[`AWD_BIT_CTRL_KBC_EN];
		end
	end

	// Software force lives for one cycle only, so it never reads back as set.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			force_sw <= 1'b0;
		end else begin
			force_sw <= wr_ctrl && reg_wdata[`AWD_BIT_CTRL_FORCE];
		end
	end

	// ***************************************************************
	// Force line and prescaler
	// ***************************************************************

	// Keyboard controller force line, turned into a pulse.
	awd_edge_det u_edge (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.kbc_force_line(kbc_force_line),
		.enable(kbc_en),
		.pulse(kbc_pulse)
	);

	// The prescaler restarts on every reload and sits idle while not counting.
	assign tif.restart = reload || (state != awd_pkg::AWD_COUNT);
	assign tif.unit_sec = unit_sec;

	awd_prescaler #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_pre (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.tif(tif)
	);

	// ***************************************************************
	// Watchdog counter
	// ***************************************************************

	// Restart requests from the enabled sources only.
	assign restart_evt = (game_port_access && src_cfg[`AWD_BIT_SRC_GAME])
		|| (kbd_irq && src_cfg[`AWD_BIT_SRC_KBD])
		|| (mouse_irq && src_cfg[`AWD_BIT_SRC_MOUSE]);
	assign armed = (count_val != `AWD_ZERO_COUNT);
	assign reload = wr_count || (armed && restart_evt);
	assign force_any = force_sw || kbc_pulse;

	// A write of the value register wins over any event in the same cycle; a restart
	// wins over a natural expiry, but a force still counts beside it.
	assign timeout_evt = armed && !wr_count && (force_any
		|| (state == awd_pkg::AWD_COUNT && tif.tick && !restart_evt
		&& remaining == `AWD_LAST_COUNT));

	// Counter state and remaining units.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state <= awd_pkg::AWD_IDLE;
			remaining <= `AWD_ZERO_COUNT;
		end else if (wr_count) begin
			remaining <= reg_wdata;
			if (reg_wdata == `AWD_ZERO_COUNT) begin
				state <= awd_pkg::AWD_IDLE;
			end else begin
				state <= awd_pkg::AWD_COUNT;
			end
		end else if (!armed) begin
			state <= awd_pkg::AWD_IDLE;
		end else if (restart_evt) begin
			remaining <= count_val;
			state <= awd_pkg::AWD_COUNT;
		end else if (timeout_evt) begin
			state <= awd_pkg::AWD_EXPIRED;
		end else if (state == awd_pkg::AWD_COUNT && tif.tick) begin
			remaining <= remaining - 8'h01;
		end
	end

	// ***************************************************************
	// Time-out status and IRQ routing
	// ***************************************************************

	// Status: a time-out in the same cycle as a software clear or a reload still sets it.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			wdt_timeout <= 1'b0;
		end else if (timeout_evt) begin
			wdt_timeout <= 1'b1;
		end else if (wr_ctrl) begin
			wdt_timeout <= reg_wdata[`AWD_BIT_CTRL_STATUS];
		end else if (reload) begin
			wdt_timeout <= 1'b0;
		end
	end

	// Mapped IRQ line follows the status bit one cycle later.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			irq_lines <= `AWD_NO_IRQ;
		end else if (wdt_timeout) begin
			irq_lines <= awd_pkg::awd_onehot(irq_map);
		end else begin
			irq_lines <= `AWD_NO_IRQ;
		end
	end

	// ***************************************************************
	// Interrupt status and mask
	// ***************************************************************

	// Sticky events; the read clears, a new event in that cycle wins.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			int_stat <= `AWD_RST_INT;
		end else begin
			int_stat[`AWD_BIT_INT_TIMEOUT] <= timeout_evt
				|| (int_stat[`AWD_BIT_INT_TIMEOUT] && !rd_stat);
			int_stat[`AWD_BIT_INT_RESTART] <= reload
				|| (int_stat[`AWD_BIT_INT_RESTART] && !rd_stat);
		end
	end

	// Mask of the same layout.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			int_mask <= `AWD_RST_INT;
		end else if (wr_mask) begin
			int_mask <= reg_wdata[`AWD_INT_W-1:0];
		end
	end

	// Level interrupt, high while any unmasked event is pending.
	assign irq = |(int_stat & int_mask);

	// ***************************************************************
	// Read path
	// ***************************************************************

	// Read mux; unmapped addresses and reserved bits read as zero.
	always_comb begin
		next_rdata = `AWD_RST_BYTE;
		case (reg_addr)
			`AWD_ADDR_UNIT: begin
				next_rdata[`AWD_BIT_UNIT_SEC] = unit_sec;
			end
			`AWD_ADDR_COUNT: begin
				next_rdata = count_val;
			end
			`AWD_ADDR_SOURCES: begin
				next_rdata = {src_cfg[6:3], 1'b0, src_cfg[2:0]};
			end
			`AWD_ADDR_CTRL: begin
				next_rdata[`AWD_BIT_CTRL_STATUS] = wdt_timeout;
				next_rdata[`AWD_BIT_CTRL_KBC_EN] = kbc_en;
			end
			`AWD_ADDR_INT_STAT: begin
				next_rdata[`AWD_INT_W-1:0] = int_stat;
			end
			`AWD_ADDR_INT_MASK: begin
				next_rdata[`AWD_INT_W-1:0] = int_mask;
			end
			default: begin
				next_rdata = `AWD_RST_BYTE;
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe, zero otherwise.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			reg_rdata <= `AWD_RST_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= `AWD_RST_BYTE;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************

	a_disabled_no_timeout:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(count_val == `AWD_ZERO_COUNT) |-> !timeout_evt ##1 (state != awd_pkg::AWD_EXPIRED
		|| wr_count || $past(wr_count)))
		else $error("time-out while value is zero");

	a_write_reloads_count:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		wr_count |=> (remaining == $past(reg_wdata)) && (count_val == $past(reg_wdata)))
		else $error("value write did not reload the counter");

	a_game_restart_gate:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(game_port_access && !src_cfg[`AWD_BIT_SRC_GAME] && !kbd_irq && !mouse_irq
		&& !wr_count && state == awd_pkg::AWD_EXPIRED && !force_any)
		|=> state == awd_pkg::AWD_EXPIRED)
		else $error("disabled game port access restarted the watchdog");

	a_kbd_restart_load:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(kbd_irq && src_cfg[`AWD_BIT_SRC_KBD] && armed && !wr_count)
		|=> (remaining == $past(count_val)) && (state == awd_pkg::AWD_COUNT))
		else $error("keyboard interrupt did not restart the count");

	a_mouse_restart_load:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(mouse_irq && src_cfg[`AWD_BIT_SRC_MOUSE] && armed && !wr_count)
		|=> (remaining == $past(count_val)) && (state == awd_pkg::AWD_COUNT))
		else $error("mouse interrupt did not restart the count");

	a_irq_route_line:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		wdt_timeout |=> irq_lines == awd_pkg::awd_onehot($past(irq_map)))
		else $error("time-out not routed to the selected IRQ line");

	a_force_sets_status:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(wr_ctrl && reg_wdata[`AWD_BIT_CTRL_FORCE] && armed) ##1 !wr_count |=> wdt_timeout)
		else $error("software force did not give a time-out");

	a_force_reads_zero:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(reg_rd && reg_addr == `AWD_ADDR_CTRL) |=> (!reg_rdata[`AWD_BIT_CTRL_FORCE]
		&& reg_rdata[`AWD_BIT_CTRL_STATUS] == $past(wdt_timeout)))
		else $error("control read gave a wrong status or force bit");

	a_expired_stays_stopped:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(state == awd_pkg::AWD_EXPIRED && !reload && armed)
		|=> (state == awd_pkg::AWD_EXPIRED) && $stable(remaining))
		else $error("expired watchdog moved without a reload");

	a_status_follows_timeout:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		timeout_evt |=> wdt_timeout && int_stat[`AWD_BIT_INT_TIMEOUT])
		else $error("time-out did not set the status bits");
endmodule

// *** rtl/awd_map.svh ***
// Register offsets, field positions, reset values and timing constants of the watchdog.
`ifndef AWD_MAP_SVH
`define AWD_MAP_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define AWD_ADDR_UNIT 8'hf1
`define AWD_ADDR_COUNT 8'hf2
`define AWD_ADDR_SOURCES 8'hf3
`define AWD_ADDR_CTRL 8'hf4
`define AWD_ADDR_INT_STAT 8'hf5
`define AWD_ADDR_INT_MASK 8'hf6

// ***************************************************************
// Field positions
// ***************************************************************
`define AWD_BIT_UNIT_SEC 7
`define AWD_BIT_SRC_GAME 0
`define AWD_BIT_SRC_KBD 1
`define AWD_BIT_SRC_MOUSE 2
`define AWD_BIT_SRC_RSVD 3
`define AWD_MAP_HI 7
`define AWD_MAP_LO 4
`define AWD_BIT_CTRL_STATUS 0
`define AWD_BIT_CTRL_FORCE 2
`define AWD_BIT_CTRL_KBC_EN 3
`define AWD_BIT_INT_TIMEOUT 0
`define AWD_BIT_INT_RESTART 1

// ***************************************************************
// Reset values and widths
// ***************************************************************
`define AWD_RST_BYTE 8'h00
`define AWD_ZERO_COUNT 8'h00
`define AWD_LAST_COUNT 8'h01
`define AWD_INT_W 2
`define AWD_RST_INT 2'h0
`define AWD_NO_IRQ 16'h0000

// ***************************************************************
// Timing
// ***************************************************************
`define AWD_CLK_PERIOD_NS 40
`define AWD_SECOND_NS 1000000000
`define AWD_SEC_PER_MIN 60

`endif

// *** rtl/awd_pkg.sv ***
// Types and shared decode functions of the watchdog.
package awd_pkg;

	// Counter state: disabled, counting, or stopped after a time-out.
	typedef enum logic [1:0] {
		AWD_IDLE = 2'b00,
		AWD_COUNT = 2'b01,
		AWD_EXPIRED = 2'b10
	} awd_state_t;

	// One-hot IRQ line decode; pattern zero selects no line at all.
	function automatic logic [15:0] awd_onehot(input logic [3:0] sel);
		logic [15:0] v;
		v = 16'h0001 << sel;
		if (sel == 4'h0) begin
			v = 16'h0000;
		end
		return v;
	endfunction

endpackage

// *** rtl/awd_tick_if.sv ***
// Carrier between the watchdog core and its unit prescaler.
`timescale 1ns/1ps
interface awd_tick_if;
	logic restart;
	logic unit_sec;
	logic tick;
	modport src (input restart, input unit_sec, output tick);
	modport snk (output restart, output unit_sec, input tick);
endinterface

// *** rtl/awd_prescaler.sv ***
// Prescaler that turns the system clock into second or minute ticks.
`timescale 1ns/1ps
`include "awd_map.svh"
module awd_prescaler #(
	parameter int SEC_CYCLES = 25000000
) (
	input wire logic clk_sys,
	input wire logic rstn,
	awd_tick_if.src tif
);
	localparam int CW = (SEC_CYCLES > 2) ? $clog2(SEC_CYCLES) : 1;

	logic [CW-1:0] cyc;
	logic [5:0] secs;
	logic sec_wrap;
	logic min_wrap;

	// Wrap points of the two stages.
	assign sec_wrap = (cyc == CW'(SEC_CYCLES - 1));
	assign min_wrap = sec_wrap && (secs == 6'(`AWD_SEC_PER_MIN - 1));

	// Cycle stage; a restart throws away the partial unit so timing starts clean.
	always_ff @(posedge clk_sys) begin
		if (!rstn || tif.restart || sec_wrap) begin
			cyc <= '0;
		end else begin
			cyc <= cyc + CW'(1);
		end
	end

	// Second stage, always running so the unit can change mid-count.
	always_ff @(posedge clk_sys) begin
		if (!rstn || tif.restart || min_wrap) begin
			secs <= '0;
		end else if (sec_wrap) begin
			secs <= secs + 6'h01;
		end
	end

	// Unit tick in whichever unit is selected right now.
	assign tif.tick = tif.unit_sec ? sec_wrap : min_wrap;
endmodule

// *** rtl/awd_edge_det.sv ***
// Rising-edge detector for the keyboard controller force line.
`timescale 1ns/1ps
module awd_edge_det (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic kbc_force_line,
	input wire logic enable,
	output logic pulse
);
	logic prev;

	// The previous level is tracked even while disabled, so enabling with the line high
	// does not fire; only a later rising edge counts.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prev <= 1'b0;
		end else begin
			prev <= kbc_force_line;
		end
	end

	// Self-clearing one-cycle pulse, however long the line stays high.
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pulse <= 1'b0;
		end else begin
			pulse <= enable && kbc_force_line && !prev;
		end
	end

	a_kbc_edge_pulse:
	assert property (@(posedge clk_sys) disable iff (!rstn)
		(enable && kbc_force_line && !prev) |=> pulse ##1 !pulse)
		else $error("force line edge did not give a single pulse");
endmodule

// *** test/testbench.sv ***
// Self-checking testbench of the watchdog block with its register port and interrupt.
`timescale 1ns/1ps
`include "awd_map.svh"
`define CMP(nm, e, g) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("FAIL %s expected %h seen %h", nm, e, g); \
	end \
end
module testbench;
	typedef struct {logic is_out; logic [17:0] val;} awd_note_t;
	logic clk_sys, rstn, reg_wr, reg_rd, kbc_force_line, probe, rd_q, wdt_timeout, irq;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
	logic [2:0] src;
	logic [15:0] irq_lines;
	awd_note_t notes[$];
	awd_note_t n;
	int error_cnt, check_count, seed, i, m;

	// A short second keeps every timed scenario within a few hundred cycles.
	awd_top #(.SEC_CYCLES(4)) awd_top_i (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.game_port_access(src[0]), .kbd_irq(src[1]), .mouse_irq(src[2]),
		.kbc_force_line(kbc_force_line), .irq_lines(irq_lines), .wdt_timeout(wdt_timeout),
		.irq(irq));

	// ***************************************************************
	// Clock, watchdog and verdict
	// ***************************************************************
	// Free-running 25 MHz system clock.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// A hang is cut short well after the longest expected run.
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		results();
	end

	task automatic results();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ***************************************************************
	// Result watcher
	// ***************************************************************
	// Read data stand one cycle after the read edge; probes sample outputs as they stand.
	always @(posedge clk_sys) begin
		rd_q <= reg_rd;
		if (rd_q) begin
			n = notes.pop_front();
			`CMP("reg_rdata", n.val[7:0], reg_rdata)
		end
		if (probe) begin
			n = notes.pop_front();
			`CMP("irq_lines,wdt_timeout,irq", n.val, {irq_lines, wdt_timeout, irq})
		end
	end

	// ***************************************************************
	// Driver tasks
	// ***************************************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		notes.push_back('{1'b0, {10'h000, e}});
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask

	task automatic chk(input logic [17:0] e);
		@(posedge clk_sys);
		probe <= 1'b1;
		notes.push_back('{1'b1, e});
		@(posedge clk_sys);
		probe <= 1'b0;
	endtask

	task automatic idle(input int c);
		repeat (c) @(posedge clk_sys);
	endtask

	task automatic pulse(input int k);
		@(posedge clk_sys);
		src[k] <= 1'b1;
		@(posedge clk_sys);
		src <= 3'b000;
	endtask

	// Clears status, then sets unit, restart sources and map, and loads the count last.
	task automatic cfg(input logic [7:0] u, input logic [7:0] s, input logic [7:0] c);
		wr(`AWD_ADDR_CTRL, 8'h00);
		wr(`AWD_ADDR_UNIT, u);
		wr(`AWD_ADDR_SOURCES, s);
		wr(`AWD_ADDR_COUNT, c);
	endtask

	// The mapped line is driven only while the status is set and the map is not zero.
	function automatic logic [17:0] ex(input logic [3:0] mp, input logic st, input logic ir);
		logic [15:0] oh;
		oh = (mp == 4'h0 || !st) ? 16'h0000 : (16'h0001 << mp);
		return {oh, st, ir};
	endfunction

	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial begin
		seed = 34;
		error_cnt = 0;
		check_count = 0;
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		src = 3'b000;
		kbc_force_line = 1'b0;
		probe = 1'b0;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		// Reset values, with unmapped neighbours reading zero.
		for (i = 8'hf0; i <= 8'hf7; i++) begin
			rd(i[7:0], 8'h00);
		end
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00);
		wr(`AWD_ADDR_UNIT, 8'h83);
		rd(`AWD_ADDR_UNIT, 8'h80);
		wr(`AWD_ADDR_UNIT, 8'h00);
		wr(`AWD_ADDR_CTRL, 8'h08);
		rd(`AWD_ADDR_CTRL, 8'h08);
		// Random values in minutes, too short a run for any expiry.
		for (i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			wr(`AWD_ADDR_SOURCES, v);
			rd(`AWD_ADDR_SOURCES, v & 8'hf7);
			wr(`AWD_ADDR_COUNT, v);
			rd(`AWD_ADDR_COUNT, v);
		end
		// A zero count refuses both kinds of force.
		cfg(8'h80, 8'h50, 8'h00);
		wr(`AWD_ADDR_CTRL, 8'h0c);
		kbc_force_line <= 1'b1;
		idle(12);
		chk(ex(5, 0, 0));
		kbc_force_line <= 1'b0;
		rd(`AWD_ADDR_INT_STAT, 8'h02);
		// Two seconds, then a stop with the mapped line and the interrupt.
		wr(`AWD_ADDR_INT_MASK, 8'h01);
		cfg(8'h80, 8'h50, 8'h02);
		idle(3);
		chk(ex(5, 0, 0));
		idle(8);
		chk(ex(5, 1, 1));
		rd(`AWD_ADDR_INT_STAT, 8'h03);
		chk(ex(5, 1, 0));
		idle(20);
		chk(ex(5, 1, 0));
		rd(`AWD_ADDR_CTRL, 8'h01);
		// One minute is sixty seconds.
		cfg(8'h00, 8'h50, 8'h01);
		idle(200);
		chk(ex(5, 0, 0));
		idle(50);
		chk(ex(5, 1, 1));
		rd(`AWD_ADDR_INT_STAT, 8'h03);
		wr(`AWD_ADDR_INT_MASK, 8'h00);
		// The status bit is writable both ways.
		wr(`AWD_ADDR_CTRL, 8'h00);
		chk(ex(5, 0, 0));
		wr(`AWD_ADDR_CTRL, 8'h01);
		chk(ex(5, 1, 0));
		// Each source restarts only while enabled; pulses come every six cycles.
		for (i = 0; i < 3; i++) begin
			cfg(8'h80, 8'hf0 | (8'h01 << i), 8'h03);
			repeat (5) begin
				idle(4);
				pulse(i);
			end
			chk(ex(15, 0, 0));
			cfg(8'h80, 8'hf0 | (8'h07 & ~(8'h01 << i)), 8'h03);
			repeat (5) begin
				idle(4);
				pulse(i);
			end
			chk(ex(15, 1, 0));
		end
		// Rewriting the count restarts timing.
		cfg(8'h80, 8'hf0, 8'h03);
		repeat (4) begin
			idle(6);
			wr(`AWD_ADDR_COUNT, 8'h03);
		end
		chk(ex(15, 0, 0));
		idle(16);
		chk(ex(15, 1, 0));
		// Software force under every map pattern.
		cfg(8'h00, 8'h00, 8'hff);
		for (m = 0; m < 16; m++) begin
			wr(`AWD_ADDR_CTRL, 8'h00);
			wr(`AWD_ADDR_SOURCES, {m[3:0], 4'h0});
			wr(`AWD_ADDR_CTRL, 8'h04);
			idle(2);
			chk(ex(m[3:0], 1, 0));
		end
		rd(`AWD_ADDR_CTRL, 8'h01);
		// A pending time-out raises the interrupt once unmasked; reading clears it.
		wr(`AWD_ADDR_INT_MASK, 8'h01);
		chk(ex(15, 1, 1));
		rd(`AWD_ADDR_INT_STAT, 8'h03);
		chk(ex(15, 1, 0));
		wr(`AWD_ADDR_INT_MASK, 8'h00);
		// Force line: ignored while disabled, edge only, software force still works.
		wr(`AWD_ADDR_CTRL, 8'h00);
		kbc_force_line <= 1'b1;
		idle(4);
		chk(ex(15, 0, 0));
		wr(`AWD_ADDR_CTRL, 8'h08);
		idle(3);
		chk(ex(15, 0, 0));
		kbc_force_line <= 1'b0;
		idle(2);
		kbc_force_line <= 1'b1;
		idle(3);
		chk(ex(15, 1, 0));
		wr(`AWD_ADDR_CTRL, 8'h08);
		idle(4);
		chk(ex(15, 0, 0));
		kbc_force_line <= 1'b0;
		wr(`AWD_ADDR_CTRL, 8'h0c);
		idle(2);
		chk(ex(15, 1, 0));
		rd(`AWD_ADDR_CTRL, 8'h09);
		idle(4);
		results();
	end
endmodule
